// [src/arc_regs.svh]
// register offsets, field positions and reset values of the region access checker
`ifndef ARC_REGS_SVH
`define ARC_REGS_SVH
`define ARC_NUM_REGIONS 16
`define ARC_USER_W 5
`define ARC_CFG_AW 16
`define ARC_REG_START_OFS 8'h00
`define ARC_REG_END_OFS 8'h04
`define ARC_REG_MASTERS_OFS 8'h08
`define ARC_REG_CONFIG_OFS 8'h0C
`define ARC_REG_CTRL_OFS 16'h1000
`define ARC_REG_SINK_OFS 16'h1004
`define ARC_REG_STATUS_OFS 16'h1008
`define ARC_CFG_EN_BIT 0
`define ARC_CFG_RD_BIT 1
`define ARC_CFG_WR_BIT 2
`define ARC_CFG_NS_BIT 3
`define ARC_CFG_STRICT_BIT 4
`define ARC_CFG_MCD_BIT 5
`define ARC_CFG_RESET 32'h0000_0006
`define ARC_CFG_MASK 32'h0000_003F
`define ARC_MASTERS_RESET 32'h0000_0004
`define ARC_MASTERS_MASK 32'h7FFF_FFFF
`define ARC_APP_PROC_ID 5'h12
`define ARC_CTRL_DEF_RD_BIT 0
`define ARC_CTRL_DEF_WR_BIT 1
`define ARC_CTRL_PSN_PROT_BIT 2
`define ARC_CTRL_PSN_REDIR_BIT 3
`define ARC_CTRL_RESET 32'h0000_000B
`define ARC_CTRL_MASK 32'h0000_000F
`define ARC_SINK_RESET 32'h0080_0000
`define ARC_STAT_RD_VIO 32'h0000_0002
`define ARC_STAT_WR_VIO 32'h0000_0004
`define ARC_STAT_SEC_VIO 32'h0000_0008
`define ARC_STAT_MASK 32'h0000_000E
`define ARC_PROT_NS_BIT 1
`define ARC_RESP_OKAY 2'h0
`define ARC_RESP_SLVERR 2'h2
`endif

// [src/arc_pkg.sv]
// types shared by the region access checker
`include "arc_regs.svh"
package arc_pkg;
	typedef struct packed {
		logic [39:0] addr;
		logic [2:0] prot;
		logic [`ARC_USER_W-1:0] user;
	} arc_addr_chan_t;
	typedef struct packed {
		logic poison;
		logic dir_vio;
		logic sec_vio;
	} arc_verdict_t;
	typedef enum logic [2:0] {
		ARC_SEL_NONE,
		ARC_SEL_START,
		ARC_SEL_END,
		ARC_SEL_MASTERS,
		ARC_SEL_CONFIG,
		ARC_SEL_CTRL,
		ARC_SEL_SINK,
		ARC_SEL_STATUS
	} arc_reg_sel_t;
endpackage

// [src/arc_region_eval.sv]
// per-region hit and permission evaluation of one address request
`timescale 1ns/1ps
`include "arc_regs.svh"
module arc_region_eval #(
	parameter int NUM_REGIONS = `ARC_NUM_REGIONS
) (
	// request
	input wire logic is_write_in,
	input wire arc_pkg::arc_addr_chan_t req_in,
	// region tables and miss default
	input wire logic [NUM_REGIONS-1:0][31:0] start_in,
	input wire logic [NUM_REGIONS-1:0][31:0] end_in,
	input wire logic [NUM_REGIONS-1:0][31:0] masters_in,
	input wire logic [NUM_REGIONS-1:0][31:0] config_in,
	input wire logic default_permit_in,
	// verdict
	output arc_pkg::arc_verdict_t verdict_out
);
	wire logic [31:0] page = req_in.addr[39:8];
	wire logic prot_ns = req_in.prot[`ARC_PROT_NS_BIT];
	wire logic [31:0] grp_onehot = 32'h1 << req_in.user;
	// app processor counts only when it issues secure transactions
	wire logic app_ok = (req_in.user != `ARC_APP_PROC_ID) || !prot_ns;
	logic [NUM_REGIONS-1:0] hit;
	logic [NUM_REGIONS-1:0] dir_bad;
	logic [NUM_REGIONS-1:0] sec_bad;
	genvar g;
	generate
		for (g = 0; g < NUM_REGIONS; g = g + 1)
		begin : g_region
			wire logic [31:0] cfg = config_in[g];
			wire logic mid_ok = (|(masters_in[g] & grp_onehot)) && app_ok;
			// secure region needs a secure request; strict ns region refuses secure ones
			wire logic level_ok = cfg[`ARC_CFG_NS_BIT] ?
				(prot_ns || !cfg[`ARC_CFG_STRICT_BIT]) : !prot_ns;
			wire logic id_ok = cfg[`ARC_CFG_MCD_BIT] || mid_ok;
			wire logic dir_ok = is_write_in ? cfg[`ARC_CFG_WR_BIT] : cfg[`ARC_CFG_RD_BIT];
			// both bounds inclusive, enable gates the match
			assign hit[g] = cfg[`ARC_CFG_EN_BIT] && page >= start_in[g] && page <= end_in[g];
			assign dir_bad[g] = hit[g] && !dir_ok;
			assign sec_bad[g] = hit[g] && dir_ok && !(id_ok && level_ok);
		end
	endgenerate
	// any failing region wins over passing overlapped ones
	assign verdict_out.dir_vio = (|dir_bad) || (!(|hit) && !default_permit_in);
	assign verdict_out.sec_vio = |sec_bad;
	assign verdict_out.poison = verdict_out.dir_vio || verdict_out.sec_vio;
endmodule

// [src/arc_axi_region_checker.sv]
// axi address-channel region access checker with its register file
// Overview of operation
// - unauthorized requester for hit region is poisoned
// - authorized-master bitmap at region offset 0x08
// - management unit bit resets to one
// - bitmap bits 30:0 writable, bit 31 zero
// - app processor authorized only when AxProt[1]=0
// - region hit checks direction permission first
// - security and identifier check after direction passes
// - any poisoning overlapped region wins
// - master check disable: secure means AxProt[1]=0
// - strict bit keeps secure requests out of ns
// - non-secure requests enter only non-secure regions
// - region security bit: 0 secure, 1 non-secure
// - write permit bit, reset one, else poisoned
// - read permit bit, reset one, else poisoned
// - enable bit gates matching; bits 31:6 zero
// - region configuration register at offset 0x0C
// - user sideband carries and keeps the identifier
// - attribute-only poisoning forces AxProt[1] high
// - default read and write permits reset set
// - redirect replaces address 39:8 with sink base
// - region bounds hold address bits 39:8
// - region miss uses global default permits
`timescale 1ns/1ps
`include "arc_regs.svh"
module arc_axi_region_checker #(
	parameter int NUM_REGIONS = `ARC_NUM_REGIONS
) (
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_in,
	// upstream write address
	input wire logic s_aw_valid_in,
	input wire arc_pkg::arc_addr_chan_t s_aw_req_in,
	output logic s_aw_ready_out,
	// downstream write address
	output logic m_aw_valid_out,
	output arc_pkg::arc_addr_chan_t m_aw_req_out,
	input wire logic m_aw_ready_in,
	// upstream read address
	input wire logic s_ar_valid_in,
	input wire arc_pkg::arc_addr_chan_t s_ar_req_in,
	output logic s_ar_ready_out,
	// downstream read address
	output logic m_ar_valid_out,
	output arc_pkg::arc_addr_chan_t m_ar_req_out,
	input wire logic m_ar_ready_in,
	// configuration port, write side
	input wire logic cfg_awvalid_in,
	input wire logic [`ARC_CFG_AW-1:0] cfg_awaddr_in,
	output logic cfg_awready_out,
	input wire logic cfg_wvalid_in,
	input wire logic [31:0] cfg_wdata_in,
	input wire logic [3:0] cfg_wstrb_in,
	output logic cfg_wready_out,
	output logic cfg_bvalid_out,
	output logic [1:0] cfg_bresp_out,
	input wire logic cfg_bready_in,
	// configuration port, read side
	input wire logic cfg_arvalid_in,
	input wire logic [`ARC_CFG_AW-1:0] cfg_araddr_in,
	output logic cfg_arready_out,
	output logic cfg_rvalid_out,
	output logic [31:0] cfg_rdata_out,
	output logic [1:0] cfg_rresp_out,
	output logic cfg_rlast_out,
	input wire logic cfg_rready_in
);
	function automatic arc_pkg::arc_reg_sel_t reg_select(input logic [`ARC_CFG_AW-1:0] a);
		reg_select = arc_pkg::ARC_SEL_NONE;
		if (a[15:12] == 4'h0 && {1'b0, a[11:8]} < 5'(NUM_REGIONS))
		begin
			case (a[7:0])
				`ARC_REG_START_OFS: reg_select = arc_pkg::ARC_SEL_START;
				`ARC_REG_END_OFS: reg_select = arc_pkg::ARC_SEL_END;
				`ARC_REG_MASTERS_OFS: reg_select = arc_pkg::ARC_SEL_MASTERS;
				`ARC_REG_CONFIG_OFS: reg_select = arc_pkg::ARC_SEL_CONFIG;
				default: reg_select = arc_pkg::ARC_SEL_NONE;
			endcase
		end
		else
		begin
			case (a)
				`ARC_REG_CTRL_OFS: reg_select = arc_pkg::ARC_SEL_CTRL;
				`ARC_REG_SINK_OFS: reg_select = arc_pkg::ARC_SEL_SINK;
				`ARC_REG_STATUS_OFS: reg_select = arc_pkg::ARC_SEL_STATUS;
				default: reg_select = arc_pkg::ARC_SEL_NONE;
			endcase
		end
	endfunction

	function automatic logic [31:0] byte_merge(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] strb, input logic [31:0] mask);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++)
		begin
			if (strb[b])
				res[b*8 +: 8] = data[b*8 +: 8];
		end
		byte_merge = res & mask;
	endfunction

	// redirect unless attribute-only poisoning is chosen; neither bit still redirects
	function automatic arc_pkg::arc_addr_chan_t poison_apply(input arc_pkg::arc_addr_chan_t req,
		input logic poison, input logic [31:0] ctrl, input logic [31:0] sink);
		poison_apply = req;
		if (poison && ctrl[`ARC_CTRL_PSN_PROT_BIT] && !ctrl[`ARC_CTRL_PSN_REDIR_BIT])
			poison_apply.prot[`ARC_PROT_NS_BIT] = 1'b1;
		else if (poison)
			poison_apply.addr[39:8] = sink;
	endfunction

	logic [NUM_REGIONS-1:0][31:0] region_start_reg;
	logic [NUM_REGIONS-1:0][31:0] region_end_reg;
	logic [NUM_REGIONS-1:0][31:0] region_masters_reg;
	logic [NUM_REGIONS-1:0][31:0] region_config_reg;
	logic [31:0] ctrl_reg;
	logic [31:0] sink_reg;
	logic [31:0] status_reg;
	logic s_aw_ready_reg;
	logic m_aw_valid_reg;
	arc_pkg::arc_addr_chan_t m_aw_req_reg;
	logic aw_poison_reg;
	logic s_ar_ready_reg;
	logic m_ar_valid_reg;
	arc_pkg::arc_addr_chan_t m_ar_req_reg;
	logic ar_poison_reg;
	logic cfg_wr_ready_reg;
	logic cfg_bvalid_reg;
	logic [1:0] cfg_bresp_reg;
	logic cfg_rd_ready_reg;
	logic cfg_rvalid_reg;
	logic [31:0] cfg_rdata_reg;
	logic [1:0] cfg_rresp_reg;
	logic [31:0] rd_value;
	arc_pkg::arc_verdict_t aw_verdict;
	arc_pkg::arc_verdict_t ar_verdict;

	// request checking, one evaluator per direction
	arc_region_eval #(.NUM_REGIONS(NUM_REGIONS)) u_aw_eval (
		.is_write_in(1'b1),
		.req_in(s_aw_req_in),
		.start_in(region_start_reg),
		.end_in(region_end_reg),
		.masters_in(region_masters_reg),
		.config_in(region_config_reg),
		.default_permit_in(ctrl_reg[`ARC_CTRL_DEF_WR_BIT]),
		.verdict_out(aw_verdict)
	);
	arc_region_eval #(.NUM_REGIONS(NUM_REGIONS)) u_ar_eval (
		.is_write_in(1'b0),
		.req_in(s_ar_req_in),
		.start_in(region_start_reg),
		.end_in(region_end_reg),
		.masters_in(region_masters_reg),
		.config_in(region_config_reg),
		.default_permit_in(ctrl_reg[`ARC_CTRL_DEF_RD_BIT]),
		.verdict_out(ar_verdict)
	);

	// one-deep stage per channel; a bubble per request keeps ready a plain flop
	wire logic aw_take = s_aw_valid_in && s_aw_ready_reg;
	wire logic ar_take = s_ar_valid_in && s_ar_ready_reg;
	wire logic aw_valid_next = aw_take || (m_aw_valid_reg && !m_aw_ready_in);
	wire logic ar_valid_next = ar_take || (m_ar_valid_reg && !m_ar_ready_in);

	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			s_aw_ready_reg <= 1'b0;
			m_aw_valid_reg <= 1'b0;
			m_aw_req_reg <= '0;
			aw_poison_reg <= 1'b0;
		end
		else
		begin
			s_aw_ready_reg <= !aw_valid_next;
			m_aw_valid_reg <= aw_valid_next;
			if (aw_take)
			begin
				m_aw_req_reg <= poison_apply(s_aw_req_in, aw_verdict.poison, ctrl_reg, sink_reg);
				aw_poison_reg <= aw_verdict.poison;
			end
		end
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			s_ar_ready_reg <= 1'b0;
			m_ar_valid_reg <= 1'b0;
			m_ar_req_reg <= '0;
			ar_poison_reg <= 1'b0;
		end
		else
		begin
			s_ar_ready_reg <= !ar_valid_next;
			m_ar_valid_reg <= ar_valid_next;
			if (ar_take)
			begin
				m_ar_req_reg <= poison_apply(s_ar_req_in, ar_verdict.poison, ctrl_reg, sink_reg);
				ar_poison_reg <= ar_verdict.poison;
			end
		end
	end

	// configuration writes: address and data taken together, single beat
	wire logic cfg_wr_fire = cfg_wr_ready_reg && cfg_awvalid_in && cfg_wvalid_in;
	wire logic cfg_wr_ready_next = cfg_awvalid_in && cfg_wvalid_in && !cfg_wr_ready_reg &&
		!cfg_bvalid_reg;
	wire arc_pkg::arc_reg_sel_t wr_sel = reg_select(cfg_awaddr_in);
	wire logic [3:0] wr_idx = cfg_awaddr_in[11:8];
	wire logic [31:0] status_clr = (cfg_wr_fire && wr_sel == arc_pkg::ARC_SEL_STATUS) ?
		byte_merge(32'h0, cfg_wdata_in, cfg_wstrb_in, `ARC_STAT_MASK) : 32'h0;
	wire logic [31:0] vio_set =
		((aw_take && aw_verdict.dir_vio) ? `ARC_STAT_WR_VIO : 32'h0) |
		((ar_take && ar_verdict.dir_vio) ? `ARC_STAT_RD_VIO : 32'h0) |
		(((aw_take && aw_verdict.sec_vio) || (ar_take && ar_verdict.sec_vio)) ?
		`ARC_STAT_SEC_VIO : 32'h0);

	always_ff @(posedge sys_clk_in)
	begin
		for (int i = 0; i < NUM_REGIONS; i++)
		begin
			if (rst_in)
			begin
				region_start_reg[i] <= 32'h0;
				region_end_reg[i] <= 32'h0;
				region_masters_reg[i] <= `ARC_MASTERS_RESET;
				region_config_reg[i] <= `ARC_CFG_RESET;
			end
			else if (cfg_wr_fire && wr_idx == 4'(i))
			begin
				case (wr_sel)
					arc_pkg::ARC_SEL_START: region_start_reg[i] <=
						byte_merge(region_start_reg[i], cfg_wdata_in, cfg_wstrb_in, 32'hFFFF_FFFF);
					arc_pkg::ARC_SEL_END: region_end_reg[i] <=
						byte_merge(region_end_reg[i], cfg_wdata_in, cfg_wstrb_in, 32'hFFFF_FFFF);
					arc_pkg::ARC_SEL_MASTERS: region_masters_reg[i] <=
						byte_merge(region_masters_reg[i], cfg_wdata_in, cfg_wstrb_in, `ARC_MASTERS_MASK);
					arc_pkg::ARC_SEL_CONFIG: region_config_reg[i] <=
						byte_merge(region_config_reg[i], cfg_wdata_in, cfg_wstrb_in, `ARC_CFG_MASK);
					default: ;
				endcase
			end
		end
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			ctrl_reg <= `ARC_CTRL_RESET;
			sink_reg <= `ARC_SINK_RESET;
			status_reg <= 32'h0;
		end
		else
		begin
			if (cfg_wr_fire && wr_sel == arc_pkg::ARC_SEL_CTRL)
				ctrl_reg <= byte_merge(ctrl_reg, cfg_wdata_in, cfg_wstrb_in, `ARC_CTRL_MASK);
			if (cfg_wr_fire && wr_sel == arc_pkg::ARC_SEL_SINK)
				sink_reg <= byte_merge(sink_reg, cfg_wdata_in, cfg_wstrb_in, 32'hFFFF_FFFF);
			// a new violation beats a simultaneous clear
			status_reg <= ((status_reg & ~status_clr) | vio_set) & `ARC_STAT_MASK;
		end
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			cfg_wr_ready_reg <= 1'b0;
			cfg_bvalid_reg <= 1'b0;
			cfg_bresp_reg <= `ARC_RESP_OKAY;
		end
		else
		begin
			cfg_wr_ready_reg <= cfg_wr_ready_next;
			cfg_bvalid_reg <= cfg_wr_fire || (cfg_bvalid_reg && !cfg_bready_in);
			if (cfg_wr_fire)
				cfg_bresp_reg <= (wr_sel == arc_pkg::ARC_SEL_NONE) ? `ARC_RESP_SLVERR : `ARC_RESP_OKAY;
		end
	end

	// configuration reads, single beat
	wire logic cfg_rd_fire = cfg_rd_ready_reg && cfg_arvalid_in;
	wire logic cfg_rd_ready_next = cfg_arvalid_in && !cfg_rd_ready_reg && !cfg_rvalid_reg;
	wire arc_pkg::arc_reg_sel_t rd_sel = reg_select(cfg_araddr_in);
	wire logic [3:0] rd_idx = cfg_araddr_in[11:8];

	always_comb
	begin
		case (rd_sel)
			arc_pkg::ARC_SEL_START: rd_value = region_start_reg[rd_idx];
			arc_pkg::ARC_SEL_END: rd_value = region_end_reg[rd_idx];
			arc_pkg::ARC_SEL_MASTERS: rd_value = region_masters_reg[rd_idx];
			arc_pkg::ARC_SEL_CONFIG: rd_value = region_config_reg[rd_idx];
			arc_pkg::ARC_SEL_CTRL: rd_value = ctrl_reg;
			arc_pkg::ARC_SEL_SINK: rd_value = sink_reg;
			arc_pkg::ARC_SEL_STATUS: rd_value = status_reg;
			default: rd_value = 32'h0;
		endcase
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			cfg_rd_ready_reg <= 1'b0;
			cfg_rvalid_reg <= 1'b0;
			cfg_rdata_reg <= 32'h0;
			cfg_rresp_reg <= `ARC_RESP_OKAY;
		end
		else
		begin
			cfg_rd_ready_reg <= cfg_rd_ready_next;
			cfg_rvalid_reg <= cfg_rd_fire || (cfg_rvalid_reg && !cfg_rready_in);
			if (cfg_rd_fire)
			begin
				cfg_rdata_reg <= rd_value;
				cfg_rresp_reg <= (rd_sel == arc_pkg::ARC_SEL_NONE) ? `ARC_RESP_SLVERR : `ARC_RESP_OKAY;
			end
		end
	end

	assign s_aw_ready_out = s_aw_ready_reg;
	assign m_aw_valid_out = m_aw_valid_reg;
	assign m_aw_req_out = m_aw_req_reg;
	assign s_ar_ready_out = s_ar_ready_reg;
	assign m_ar_valid_out = m_ar_valid_reg;
	assign m_ar_req_out = m_ar_req_reg;
	assign cfg_awready_out = cfg_wr_ready_reg;
	assign cfg_wready_out = cfg_wr_ready_reg;
	assign cfg_bvalid_out = cfg_bvalid_reg;
	assign cfg_bresp_out = cfg_bresp_reg;
	assign cfg_arready_out = cfg_rd_ready_reg;
	assign cfg_rvalid_out = cfg_rvalid_reg;
	assign cfg_rdata_out = cfg_rdata_reg;
	assign cfg_rresp_out = cfg_rresp_reg;
	assign cfg_rlast_out = cfg_rvalid_reg;

	property p_aw_forward;
		@(posedge sys_clk_in) disable iff (rst_in)
		aw_take |=> m_aw_valid_out;
	endproperty
	a_aw_forward: assert property (p_aw_forward) else $error("accepted write not forwarded");

	property p_redirect;
		@(posedge sys_clk_in) disable iff (rst_in)
		(aw_take && aw_verdict.poison && ctrl_reg[`ARC_CTRL_PSN_REDIR_BIT]) |=>
		(m_aw_req_out.addr == {$past(sink_reg), $past(s_aw_req_in.addr[7:0])});
	endproperty
	a_redirect: assert property (p_redirect) else $error("poisoned write not redirected");

	property p_prot_poison;
		@(posedge sys_clk_in) disable iff (rst_in)
		(ar_take && ar_verdict.poison && ctrl_reg[`ARC_CTRL_PSN_PROT_BIT] &&
		!ctrl_reg[`ARC_CTRL_PSN_REDIR_BIT]) |=> (m_ar_req_out.prot[`ARC_PROT_NS_BIT] &&
		m_ar_req_out.addr == $past(s_ar_req_in.addr));
	endproperty
	a_prot_poison: assert property (p_prot_poison) else $error("attribute poison wrong");

	property p_clean_pass;
		@(posedge sys_clk_in) disable iff (rst_in)
		(ar_take && !ar_verdict.poison) |=> (m_ar_req_out == $past(s_ar_req_in)) && !ar_poison_reg;
	endproperty
	a_clean_pass: assert property (p_clean_pass) else $error("clean read altered");

	property p_user_kept;
		@(posedge sys_clk_in) disable iff (rst_in)
		aw_take |=> (m_aw_req_out.user == $past(s_aw_req_in.user)) && (aw_poison_reg ==
		$past(aw_verdict.poison));
	endproperty
	a_user_kept: assert property (p_user_kept) else $error("user sideband lost");

	property p_reset_masters;
		@(posedge sys_clk_in)
		$past(rst_in) |-> (region_masters_reg[0] == 32'h0000_0004 &&
		region_config_reg[0] == 32'h0000_0006);
	endproperty
	a_reset_masters: assert property (p_reset_masters) else $error("region reset wrong");

	property p_default_permit;
		@(posedge sys_clk_in)
		$past(rst_in) |-> (ctrl_reg[`ARC_CTRL_DEF_RD_BIT] && ctrl_reg[`ARC_CTRL_DEF_WR_BIT]);
	endproperty
	a_default_permit: assert property (p_default_permit) else $error("defaults not set");

	// watch the read path, not the stored word, so a decode slip shows too
	property p_rsvd_bit;
		@(posedge sys_clk_in) disable iff (rst_in)
		(cfg_rd_fire && (rd_sel == arc_pkg::ARC_SEL_MASTERS ||
		rd_sel == arc_pkg::ARC_SEL_CONFIG)) |=> !cfg_rdata_out[31] &&
		(cfg_rdata_out[31:6] == 26'h0 || $past(rd_sel) == arc_pkg::ARC_SEL_MASTERS);
	endproperty
	a_rsvd_bit: assert property (p_rsvd_bit) else $error("reserved bit set");

	property p_wr_vio;
		@(posedge sys_clk_in) disable iff (rst_in)
		(aw_take && aw_verdict.dir_vio) |=> status_reg[2] ##1 (status_reg[2] || $past(status_clr[2]));
	endproperty
	a_wr_vio: assert property (p_wr_vio) else $error("write violation not recorded");
endmodule

// [tb/arc_sink_model.sv]
// downstream address-channel sink model with a selectable stall
`timescale 1ns/1ps
module arc_sink_model #(
	parameter int STALL = 0
) (
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_in,
	// address channel from the checker, same width on both sides
	input wire logic valid_in,
	input wire arc_pkg::arc_addr_chan_t req_in,
	output logic ready_out
);
	int wait_cnt;
	// ready only after valid is seen, dropped right after the handshake
	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in || ready_out || !valid_in)
		begin
			ready_out <= 1'h0;
			wait_cnt <= 0;
		end
		else if (wait_cnt >= STALL)
			ready_out <= 1'h1;
		else
			wait_cnt <= wait_cnt + 1;
	end
endmodule

// [tb/tb_top.sv]
// self-checking bench of the axi region access checker
`timescale 1ns/1ps
`include "arc_regs.svh"
module tb_top;
	logic sys_clk_in, rst_in, s_aw_valid_in, s_aw_ready_out, m_aw_valid_out, m_aw_ready_in;
	logic s_ar_valid_in, s_ar_ready_out, m_ar_valid_out, m_ar_ready_in;
	arc_pkg::arc_addr_chan_t s_aw_req_in, m_aw_req_out, s_ar_req_in, m_ar_req_out;
	logic cfg_awvalid_in, cfg_awready_out, cfg_wvalid_in, cfg_wready_out, cfg_bvalid_out;
	logic cfg_bready_in, cfg_arvalid_in, cfg_arready_out, cfg_rvalid_out, cfg_rlast_out;
	logic cfg_rready_in;
	logic [15:0] cfg_awaddr_in, cfg_araddr_in;
	logic [31:0] cfg_wdata_in, cfg_rdata_out, sink;
	logic [3:0] cfg_wstrb_in;
	logic [1:0] cfg_bresp_out, cfg_rresp_out;
	int errors, checks_done, cycles;
	logic by_prot;

	arc_axi_region_checker #(.NUM_REGIONS(16)) i_arc_axi_region_checker (.sys_clk_in, .rst_in,
		.s_aw_valid_in, .s_aw_req_in, .s_aw_ready_out, .m_aw_valid_out, .m_aw_req_out,
		.m_aw_ready_in, .s_ar_valid_in, .s_ar_req_in, .s_ar_ready_out, .m_ar_valid_out,
		.m_ar_req_out, .m_ar_ready_in, .cfg_awvalid_in, .cfg_awaddr_in, .cfg_awready_out,
		.cfg_wvalid_in, .cfg_wdata_in, .cfg_wstrb_in, .cfg_wready_out, .cfg_bvalid_out,
		.cfg_bresp_out, .cfg_bready_in, .cfg_arvalid_in, .cfg_araddr_in, .cfg_arready_out,
		.cfg_rvalid_out, .cfg_rdata_out, .cfg_rresp_out, .cfg_rlast_out, .cfg_rready_in);
	// prompt sink on writes, slow sink on reads
	arc_sink_model #(.STALL(0)) i_sink_aw (.sys_clk_in, .rst_in, .valid_in(m_aw_valid_out),
		.req_in(m_aw_req_out), .ready_out(m_aw_ready_in));
	arc_sink_model #(.STALL(3)) i_sink_ar (.sys_clk_in, .rst_in, .valid_in(m_ar_valid_out),
		.req_in(m_ar_req_out), .ready_out(m_ar_ready_in));

	initial
	begin
		sys_clk_in = 1'h0;
		forever #5 sys_clk_in = ~sys_clk_in;
	end

	task automatic complete_run();
		$display("errors %0d checks_done %0d", errors, checks_done);
		if (errors == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// hang guard, a few hundred cycles are expected
	always @(posedge sys_clk_in)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			errors++;
			$display("mismatch at %0t: run took too long", $time);
			complete_run();
		end
	end

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			errors++;
			$display("mismatch at %0t: word %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_req(input arc_pkg::arc_addr_chan_t got, input arc_pkg::arc_addr_chan_t exp);
		checks_done++;
		if (got !== exp)
		begin
			errors++;
			$display("mismatch at %0t: request %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cfg_write(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		@(posedge sys_clk_in);
		cfg_awvalid_in <= 1'h1;
		cfg_wvalid_in <= 1'h1;
		cfg_awaddr_in <= a;
		cfg_wdata_in <= d;
		cfg_bready_in <= 1'h1;
		n = 0;
		do
			@(posedge sys_clk_in);
		while (cfg_awready_out !== 1'h1 && ++n < 20);
		chk_word({31'h0, cfg_wready_out}, 32'h1);
		cfg_awvalid_in <= 1'h0;
		cfg_wvalid_in <= 1'h0;
		do
			@(posedge sys_clk_in);
		while (cfg_bvalid_out !== 1'h1 && ++n < 40);
		cfg_bready_in <= 1'h0;
		chk_word({30'h0, cfg_bresp_out}, {30'h0, er});
	endtask

	task automatic cfg_read(input logic [15:0] a, input logic [31:0] exp, input logic [1:0] er);
		int n;
		@(posedge sys_clk_in);
		cfg_arvalid_in <= 1'h1;
		cfg_araddr_in <= a;
		cfg_rready_in <= 1'h1;
		n = 0;
		do
			@(posedge sys_clk_in);
		while (cfg_arready_out !== 1'h1 && ++n < 20);
		cfg_arvalid_in <= 1'h0;
		do
			@(posedge sys_clk_in);
		while (cfg_rvalid_out !== 1'h1 && ++n < 40);
		chk_word({31'h0, cfg_rlast_out}, 32'h1);
		cfg_rready_in <= 1'h0;
		chk_word({30'h0, cfg_rresp_out}, {30'h0, er});
		if (er == 2'h0)
			chk_word(cfg_rdata_out, exp);
	endtask

	task automatic set_region(input logic [3:0] r, input logic [31:0] lo, input logic [31:0] hi,
		input logic [31:0] ms, input logic [31:0] cf);
		cfg_write({4'h0, r, `ARC_REG_START_OFS}, lo, 2'h0);
		cfg_write({4'h0, r, `ARC_REG_END_OFS}, hi, 2'h0);
		cfg_write({4'h0, r, `ARC_REG_MASTERS_OFS}, ms, 2'h0);
		cfg_write({4'h0, r, `ARC_REG_CONFIG_OFS}, cf, 2'h0);
	endtask

	// one address request; a poisoned one is redirected or marked non-secure
	task automatic xfer(input logic wr, input logic [39:0] a, input logic [2:0] p,
		input logic [4:0] u, input logic psn);
		arc_pkg::arc_addr_chan_t rq;
		arc_pkg::arc_addr_chan_t ex;
		int n;
		rq = '{addr: a, prot: p, user: u};
		ex = rq;
		if (psn && by_prot)
			ex.prot[1] = 1'h1;
		else if (psn)
			ex.addr = {sink, a[7:0]};
		@(posedge sys_clk_in);
		s_aw_valid_in <= wr;
		s_ar_valid_in <= !wr;
		s_aw_req_in <= rq;
		s_ar_req_in <= rq;
		n = 0;
		do
			@(posedge sys_clk_in);
		while ((wr ? s_aw_ready_out : s_ar_ready_out) !== 1'h1 && ++n < 50);
		s_aw_valid_in <= 1'h0;
		s_ar_valid_in <= 1'h0;
		do
			@(posedge sys_clk_in);
		while ((wr ? m_aw_valid_out && m_aw_ready_in : m_ar_valid_out && m_ar_ready_in) !== 1'h1
			&& ++n < 50);
		chk_req(wr ? m_aw_req_out : m_ar_req_out, ex);
	endtask

	task automatic t_reset_values();
		cfg_read(16'h000C, 32'h0000_0006, 2'h0);
		cfg_read(16'h0308, 32'h0000_0004, 2'h0);
		cfg_read(16'h0F0C, 32'h0000_0006, 2'h0);
		cfg_read(16'h1000, 32'h0000_000B, 2'h0);
		cfg_read(16'h2000, 32'h0000_0000, 2'h2);
		cfg_write(16'h2000, 32'hFFFF_FFFF, 2'h2);
		cfg_write(16'h0008, 32'hFFFF_FFFF, 2'h0);
		cfg_read(16'h0008, 32'h7FFF_FFFF, 2'h0);
		cfg_write(16'h000C, 32'hFFFF_FFFF, 2'h0);
		cfg_read(16'h000C, 32'h0000_003F, 2'h0);
	endtask

	task automatic t_region_hit();
		set_region(4'h0, 32'h10, 32'h1F, 32'h4, 32'h7);
		cfg_read(16'h0008, 32'h0000_0004, 2'h0);
		cfg_read(16'h0004, 32'h0000_001F, 2'h0);
		xfer(1'h1, 40'h10_00, 3'h0, 5'h02, 1'h0);
		xfer(1'h0, 40'h1F_FF, 3'h0, 5'h02, 1'h0);
		xfer(1'h1, 40'h20_00, 3'h0, 5'h03, 1'h0);
		xfer(1'h1, 40'h0F_FF, 3'h0, 5'h03, 1'h0);
		xfer(1'h0, 40'h1F_80, 3'h0, 5'h03, 1'h1);
		xfer(1'h1, 40'h15_3C, 3'h0, 5'h1F, 1'h1);
	endtask

	task automatic t_direction();
		cfg_write(16'h000C, 32'h5, 2'h0);
		xfer(1'h0, 40'h12_00, 3'h0, 5'h02, 1'h1);
		xfer(1'h1, 40'h12_00, 3'h0, 5'h02, 1'h0);
		cfg_write(16'h000C, 32'h3, 2'h0);
		xfer(1'h1, 40'h12_04, 3'h0, 5'h02, 1'h1);
		cfg_write(16'h1008, 32'hE, 2'h0);
		cfg_write(16'h000C, 32'h5, 2'h0);
		xfer(1'h0, 40'h12_08, 3'h0, 5'h03, 1'h1);
		cfg_read(16'h1008, 32'h0000_0002, 2'h0);
	endtask

	task automatic t_security();
		set_region(4'h0, 32'h10, 32'h1F, 32'h0004_0004, 32'h7);
		xfer(1'h1, 40'h11_00, 3'h0, 5'h12, 1'h0);
		xfer(1'h1, 40'h11_00, 3'h2, 5'h12, 1'h1);
		xfer(1'h0, 40'h11_00, 3'h0, 5'h11, 1'h1);
		cfg_write(16'h000C, 32'h27, 2'h0);
		xfer(1'h0, 40'h11_10, 3'h0, 5'h03, 1'h0);
		xfer(1'h0, 40'h11_10, 3'h2, 5'h03, 1'h1);
		cfg_write(16'h000C, 32'h1F, 2'h0);
		xfer(1'h1, 40'h11_20, 3'h0, 5'h02, 1'h1);
		xfer(1'h1, 40'h11_20, 3'h2, 5'h02, 1'h0);
		cfg_write(16'h000C, 32'h0F, 2'h0);
		xfer(1'h1, 40'h11_30, 3'h0, 5'h02, 1'h0);
		xfer(1'h0, 40'h11_30, 3'h2, 5'h03, 1'h1);
	endtask

	task automatic t_overlap_and_miss();
		cfg_write(16'h000C, 32'h7, 2'h0);
		set_region(4'h1, 32'h18, 32'h30, 32'h4, 32'h3);
		xfer(1'h1, 40'h18_00, 3'h0, 5'h02, 1'h1);
		xfer(1'h1, 40'h12_00, 3'h0, 5'h02, 1'h0);
		xfer(1'h0, 40'h18_00, 3'h0, 5'h02, 1'h0);
		cfg_write(16'h010C, 32'h2, 2'h0);
		xfer(1'h1, 40'h18_00, 3'h0, 5'h02, 1'h0);
		set_region(4'h2, 32'hFFFF_FF00, 32'hFFFF_FFFF, 32'h4, 32'h3);
		xfer(1'h1, 40'hFF_FFFF_FF40, 3'h0, 5'h02, 1'h1);
		cfg_write(16'h1000, 32'h9, 2'h0);
		xfer(1'h1, 40'h40_00, 3'h0, 5'h02, 1'h1);
		xfer(1'h0, 40'h40_00, 3'h0, 5'h02, 1'h0);
	endtask

	task automatic t_poison_modes();
		cfg_write(16'h1000, 32'h7, 2'h0);
		by_prot = 1'h1;
		xfer(1'h1, 40'h1F_80, 3'h0, 5'h03, 1'h1);
		xfer(1'h0, 40'h1F_90, 3'h0, 5'h03, 1'h1);
		cfg_write(16'h1000, 32'hB, 2'h0);
		by_prot = 1'h0;
		cfg_write(16'h1004, 32'h00AB_CDEF, 2'h0);
		sink = 32'h00AB_CDEF;
		xfer(1'h0, 40'h1F_A5, 3'h0, 5'h03, 1'h1);
		cfg_read(16'h1004, 32'h00AB_CDEF, 2'h0);
		// byte lane 1 only, the rest of the sink base must survive
		cfg_wstrb_in <= 4'h2;
		cfg_write(16'h1004, 32'h0000_1100, 2'h0);
		cfg_wstrb_in <= 4'hF;
		sink = 32'h00AB_11EF;
		cfg_read(16'h1004, 32'h00AB_11EF, 2'h0);
		// both poison modes set, then neither: redirect either way
		cfg_write(16'h1000, 32'hF, 2'h0);
		xfer(1'h1, 40'h1F_C1, 3'h0, 5'h03, 1'h1);
		cfg_write(16'h1000, 32'h3, 2'h0);
		xfer(1'h0, 40'h1F_D2, 3'h0, 5'h03, 1'h1);
	endtask

	initial
	begin
		{s_aw_valid_in, s_ar_valid_in, cfg_awvalid_in, cfg_wvalid_in} = 4'h0;
		{cfg_bready_in, cfg_arvalid_in, cfg_rready_in, by_prot} = 4'h0;
		s_aw_req_in = '0;
		s_ar_req_in = '0;
		cfg_awaddr_in = 16'h0;
		cfg_araddr_in = 16'h0;
		cfg_wdata_in = 32'h0;
		cfg_wstrb_in = 4'hF;
		sink = 32'h0080_0000;
		rst_in = 1'h1;
		repeat (2) @(posedge sys_clk_in);
		rst_in <= 1'h0;
		repeat (3) @(posedge sys_clk_in);
		t_reset_values();
		t_region_hit();
		t_direction();
		t_security();
		t_overlap_and_miss();
		t_poison_modes();
		complete_run();
	end
endmodule
